// File: sleep_wake_pkg.sv
// Shared constants and types for the core sleep and wake controller.
// Assumes a single core clock domain and a 32-bit AXI4-Lite register bus.
`default_nettype none

package sleep_wake_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET        = 8'h00;
  localparam logic [7:0] STATUS_OFFSET      = 8'h04;
  localparam logic [7:0] ENTRY_COUNT_OFFSET = 8'h08;

  // Field positions in the system control register
  localparam int unsigned SAH_POS  = 1;
  localparam int unsigned DEEP_POS = 2;
  localparam int unsigned PRE_POS  = 4;

  // Field positions in the status register
  localparam int unsigned ST_SLEEP_POS    = 0;
  localparam int unsigned ST_DEEP_POS     = 1;
  localparam int unsigned ST_EVENT_POS    = 2;
  localparam int unsigned ST_DEFER_POS    = 3;
  localparam int unsigned ST_CAUSE_LO_POS = 4;
  localparam int unsigned ST_CAUSE_HI_POS = 5;

  // Values after reset
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register selector codes
  localparam logic [1:0] SEL_CTRL   = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_COUNT  = 2'h2;
  localparam logic [1:0] SEL_NONE   = 2'h3;

  typedef enum {
    st_awake,
    st_sleep_interrupt,
    st_sleep_event
  } sleep_state_t;

  typedef enum logic [1:0] {
    cause_none      = 2'h0,
    cause_exception = 2'h1,
    cause_deferred  = 2'h2,
    cause_event     = 2'h3
  } wake_cause_t;

  typedef struct packed {
    logic pending_raises_event_bit;
    logic deep_sleep_select_bit;
    logic sleep_after_handler_bit;
  } ctrl_t;

  typedef struct packed {
    logic wait_interrupt_instruction;
    logic wait_event_instruction;
    logic send_event_instruction;
    logic return_to_thread;
  } pipe_req_t;

  typedef struct packed {
    logic entry_ok;
    logic above_priority;
    logic new_pending;
  } irq_status_t;

endpackage

`default_nettype wire

// File: event_latch.sv
// One-bit event latch that decides whether a wait-for-event sleeps.
// Assumes all inputs are synchronous one-cycle or level signals on clk.
`default_nettype none
`timescale 1ns/100ps

module event_latch (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Event sources
  input  wire logic event_in,
  input  wire logic peer_send_event,
  input  wire logic local_send_event,
  input  wire logic pending_event,
  // Consume request
  input  wire logic consume,
  // State
  output var  logic latch_q
);

  logic set_any;

  assign set_any = event_in | peer_send_event | local_send_event |
                   pending_event;

  // A new event in the consume cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= 1'b0;
    end else if (set_any) begin
      latch_q <= 1'b1;
    end else if (consume) begin
      latch_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: core_sleep_wake_control.sv
// Sleep entry and wake-up control for a small processor core.
// Assumes the pipeline and interrupt controller share clk and rst, and
// that software reaches the control bits over an AXI4-Lite slave port.
`default_nettype none
`timescale 1ns/100ps

// How it works
// - The wait-for-event sleep path is a build option, off by default.
// - Wait-for-event with the event latch clear halts and sleeps.
// - Wait-for-event with the latch set clears it and keeps running.
// - External events and peer send-event instructions set the latch.
// - No register read or write reaches the event latch.
// - With sleep-after-handler set, a return to Thread mode sleeps.
// - Interrupt-style sleep wakes on an exception fit for entry or on a masked one above priority.
// - With the priority mask set, a qualifying interrupt still wakes an interrupt-style sleep.
// - Event sleep wakes on an entry-ready exception or on any event that has set the latch.
// - With pending-raises-event set, any new pending irq is an event.
// - Wait-for-interrupt sleeps at once with nothing checked.
// - The deep-sleep select bit picks ordinary or deep sleep.
module core_sleep_wake_control #(
  parameter int unsigned ADDR_W     = 8,
  parameter bit          WFE_ENABLE = 1'b0
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]         awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output var  logic                      awready,
  // AXI4-Lite write data
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output var  logic                      wready,
  // AXI4-Lite write response
  output var  logic [1:0]                bresp,
  output var  logic                      bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]         araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output var  logic                      arready,
  // AXI4-Lite read data
  output var  logic [31:0]               rdata,
  output var  logic [1:0]                rresp,
  output var  logic                      rvalid,
  input  wire logic                      rready,
  // Pipeline
  input  wire sleep_wake_pkg::pipe_req_t pipe_req,
  input  wire logic                      priority_mask_bit,
  output var  logic                      wait_event_continue,
  // Interrupt controller
  input  wire sleep_wake_pkg::irq_status_t irq,
  // System events
  input  wire logic                      event_in,
  input  wire logic                      peer_send_event,
  output var  logic                      event_out,
  // Clock controller
  output var  logic                      sleeping,
  output var  logic                      sleep_deep,
  output var  logic                      wake
);

  // Address decode shared by both bus directions
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (a == sleep_wake_pkg::CTRL_OFFSET) begin
      reg_sel = sleep_wake_pkg::SEL_CTRL;
    end else if (a == sleep_wake_pkg::STATUS_OFFSET) begin
      reg_sel = sleep_wake_pkg::SEL_STATUS;
    end else if (a == sleep_wake_pkg::ENTRY_COUNT_OFFSET) begin
      reg_sel = sleep_wake_pkg::SEL_COUNT;
    end else begin
      reg_sel = sleep_wake_pkg::SEL_NONE;
    end
  endfunction

  sleep_wake_pkg::ctrl_t        ctrl_q;
  sleep_wake_pkg::sleep_state_t state_q;
  sleep_wake_pkg::sleep_state_t state_d;
  sleep_wake_pkg::wake_cause_t  cause_q;
  sleep_wake_pkg::wake_cause_t  cause_d;

  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  logic [1:0]        wr_sel;
  logic [1:0]        rd_sel;
  logic [31:0]       rd_value;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  logic              evt_q;
  logic              evt_consume;
  logic              pend_event;
  logic              deep_q;
  logic              event_out_q;
  logic [15:0]       count_q;
  logic              wake_interrupt;
  logic              wake_event;
  logic              wake_now;
  logic              enter_interrupt;
  logic              enter_event;
  logic              event_skip;
  logic              deferred;

  // ---- Write channels: address and data taken in either order ----

  assign awready = !aw_got_q && !bvalid_q;
  assign wready  = !w_got_q && !bvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wr_sel  = reg_sel(aw_addr_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_q  <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_got_q  <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_got_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_got_q  <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_got_q  <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_got_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= sleep_wake_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (wr_sel == sleep_wake_pkg::SEL_NONE) begin
        bresp_q <= sleep_wake_pkg::RESP_DECERR;
      end else begin
        bresp_q <= sleep_wake_pkg::RESP_OKAY;
      end
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // Only the control register is writable; status and count ignore writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q.sleep_after_handler_bit  <=
        sleep_wake_pkg::CTRL_RESET[sleep_wake_pkg::SAH_POS];
      ctrl_q.deep_sleep_select_bit    <=
        sleep_wake_pkg::CTRL_RESET[sleep_wake_pkg::DEEP_POS];
      ctrl_q.pending_raises_event_bit <=
        sleep_wake_pkg::CTRL_RESET[sleep_wake_pkg::PRE_POS];
    end else if (wr_fire && wr_sel == sleep_wake_pkg::SEL_CTRL &&
                 w_strb_q[0]) begin
      ctrl_q.sleep_after_handler_bit  <= w_data_q[sleep_wake_pkg::SAH_POS];
      ctrl_q.deep_sleep_select_bit    <= w_data_q[sleep_wake_pkg::DEEP_POS];
      ctrl_q.pending_raises_event_bit <= w_data_q[sleep_wake_pkg::PRE_POS];
    end
  end

  // ---- Read channel ----

  assign arready = !rvalid_q;
  assign rd_sel  = reg_sel(araddr);

  // The event latch has no bit in any register
  always_comb begin
    rd_value = '0;
    unique case (rd_sel)
      sleep_wake_pkg::SEL_CTRL: begin
        rd_value[sleep_wake_pkg::SAH_POS]  = ctrl_q.sleep_after_handler_bit;
        rd_value[sleep_wake_pkg::DEEP_POS] = ctrl_q.deep_sleep_select_bit;
        rd_value[sleep_wake_pkg::PRE_POS]  =
          ctrl_q.pending_raises_event_bit;
      end
      sleep_wake_pkg::SEL_STATUS: begin
        rd_value[sleep_wake_pkg::ST_SLEEP_POS] =
          (state_q != sleep_wake_pkg::st_awake);
        rd_value[sleep_wake_pkg::ST_DEEP_POS]  = deep_q;
        rd_value[sleep_wake_pkg::ST_EVENT_POS] =
          (state_q == sleep_wake_pkg::st_sleep_event);
        rd_value[sleep_wake_pkg::ST_DEFER_POS] = deferred;
        rd_value[sleep_wake_pkg::ST_CAUSE_HI_POS:
                 sleep_wake_pkg::ST_CAUSE_LO_POS] = cause_q;
      end
      sleep_wake_pkg::SEL_COUNT: begin
        rd_value[15:0] = count_q;
      end
      sleep_wake_pkg::SEL_NONE: begin
        rd_value = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= sleep_wake_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_value;
      if (rd_sel == sleep_wake_pkg::SEL_NONE) begin
        rresp_q <= sleep_wake_pkg::RESP_DECERR;
      end else begin
        rresp_q <= sleep_wake_pkg::RESP_OKAY;
      end
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // ---- Event latch ----

  assign pend_event = ctrl_q.pending_raises_event_bit &
                      irq.new_pending;

  event_latch u_event_latch (
    .clk              (clk),
    .rst              (rst),
    .event_in         (event_in),
    .peer_send_event  (peer_send_event),
    .local_send_event (pipe_req.send_event_instruction),
    .pending_event    (pend_event),
    .consume          (evt_consume),
    .latch_q          (evt_q)
  );

  // Local send-event is also broadcast to other cores
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_out_q <= 1'b0;
    end else begin
      event_out_q <= pipe_req.send_event_instruction;
    end
  end

  assign event_out = event_out_q;

  // ---- Sleep entry and wake decisions ----

  assign enter_interrupt = pipe_req.wait_interrupt_instruction |
                           (pipe_req.return_to_thread &
                            ctrl_q.sleep_after_handler_bit);
  assign enter_event = WFE_ENABLE &&
                       pipe_req.wait_event_instruction && !evt_q;
  assign event_skip  = WFE_ENABLE &&
                       pipe_req.wait_event_instruction && evt_q;

  // Masked interrupt that still qualifies: wake, handler waits for unmask
  assign deferred = priority_mask_bit & irq.above_priority;

  assign wake_interrupt = irq.entry_ok | deferred;
  assign wake_event     = irq.entry_ok | evt_q;

  always_comb begin
    wake_now = 1'b0;
    unique case (state_q)
      sleep_wake_pkg::st_awake:           wake_now = 1'b0;
      sleep_wake_pkg::st_sleep_interrupt: wake_now = wake_interrupt;
      sleep_wake_pkg::st_sleep_event:     wake_now = wake_event;
    endcase
  end

  // Latch is spent on a skipped wait or on an event that woke the core
  assign evt_consume = event_skip |
                       (state_q == sleep_wake_pkg::st_sleep_event &&
                        wake_now && evt_q);

  // Without the build option a wait-for-event simply retires
  assign wait_event_continue = WFE_ENABLE ? event_skip :
                               pipe_req.wait_event_instruction;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sleep_wake_pkg::st_awake: begin
        if (enter_interrupt) begin
          state_d = sleep_wake_pkg::st_sleep_interrupt;
        end else if (enter_event) begin
          state_d = sleep_wake_pkg::st_sleep_event;
        end
      end
      sleep_wake_pkg::st_sleep_interrupt,
      sleep_wake_pkg::st_sleep_event: begin
        if (wake_now) begin
          state_d = sleep_wake_pkg::st_awake;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= sleep_wake_pkg::st_awake;
    end else begin
      state_q <= state_d;
    end
  end

  // Sleep depth is fixed at entry so a later control write cannot glitch it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deep_q <= 1'b0;
    end else if (state_q == sleep_wake_pkg::st_awake &&
                 state_d != sleep_wake_pkg::st_awake) begin
      deep_q <= ctrl_q.deep_sleep_select_bit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= sleep_wake_pkg::COUNT_RESET;
    end else if (state_q == sleep_wake_pkg::st_awake &&
                 state_d != sleep_wake_pkg::st_awake) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Record why the core last woke
  always_comb begin
    cause_d = cause_q;
    if (wake_now) begin
      if (irq.entry_ok) begin
        cause_d = sleep_wake_pkg::cause_exception;
      end else if (state_q == sleep_wake_pkg::st_sleep_event) begin
        cause_d = sleep_wake_pkg::cause_event;
      end else begin
        cause_d = sleep_wake_pkg::cause_deferred;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_q <= sleep_wake_pkg::cause_none;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ---- Clock controller qualifiers ----

  assign sleeping   = (state_q != sleep_wake_pkg::st_awake) &&
                      !wake_now;
  assign sleep_deep = sleeping && deep_q;
  assign wake       = wake_now;

endmodule

`default_nettype wire

// File: core_sleep_wake_control_properties.sv
// Concurrent checks on the sleep and wake controller's ports.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none

module sleep_wake_checker (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst,
  // Register bus handshakes
  input wire logic                        arvalid,
  input wire logic                        arready,
  input wire logic                        rvalid,
  input wire logic [1:0]                  bresp,
  input wire logic                        bvalid,
  input wire logic                        bready,
  // Pipeline and interrupt controller
  input wire sleep_wake_pkg::pipe_req_t   pipe_req,
  input wire logic                        priority_mask_bit,
  input wire logic                        wait_event_continue,
  input wire sleep_wake_pkg::irq_status_t irq,
  // Events and clock controller
  input wire logic                        event_in,
  input wire logic                        peer_send_event,
  input wire logic                        event_out,
  input wire logic                        sleeping,
  input wire logic                        sleep_deep,
  input wire logic                        wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Entered sleep, or already woken by a cause in the same cycle
  sequence s_down;
    sleeping || wake;
  endsequence

  // No external event, peer event or new pending interrupt present in a cycle
  sequence s_quiet;
    !event_in && !peer_send_event && !irq.new_pending;
  endsequence

  a_wint_enters: assert property (
    pipe_req.wait_interrupt_instruction && !sleeping |=> s_down)
    else $error("wait for interrupt did not enter sleep");
  a_wevt_enters: assert property (
    pipe_req.wait_event_instruction && !wait_event_continue &&
    !pipe_req.wait_interrupt_instruction && !sleeping |=> s_down)
    else $error("wait for event with clear latch did not sleep");
  a_wevt_skips: assert property (
    pipe_req.wait_event_instruction && wait_event_continue &&
    !pipe_req.wait_interrupt_instruction |=> !sleeping)
    else $error("wait for event with set latch slept");
  a_irq_wakes: assert property (
    sleeping ##1 irq.entry_ok |-> wake)
    else $error("entry-ready exception did not wake");
  a_mask_wakes: assert property (
    sleeping ##1 (priority_mask_bit && irq.above_priority) |-> wake)
    else $error("masked interrupt did not wake");
  a_stay_asleep: assert property (
    sleeping ##0 s_quiet ##1
    (s_quiet and (!irq.entry_ok && !irq.above_priority)) |-> !wake)
    else $error("woke with no cause");
  a_wake_drops: assert property (
    wake |-> !sleeping && !sleep_deep ##1 !wake && !sleeping)
    else $error("sleep outputs stood through wake");
  a_deep_qual: assert property (
    sleep_deep |-> sleeping)
    else $error("deep qualifier without sleep");
  a_send_out: assert property (
    pipe_req.send_event_instruction && !sleeping |=> event_out)
    else $error("send event gave no event pulse");
  a_rst_clear: assert property (
    $fell(rst) |-> !sleeping && !event_out && !wake)
    else $error("not awake after reset");
  a_rd_answer: assert property (
    arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_b_holds: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule

bind core_sleep_wake_control sleep_wake_checker u_chk (
  .clk, .rst, .arvalid, .arready, .rvalid, .bresp, .bvalid, .bready,
  .pipe_req, .priority_mask_bit, .wait_event_continue, .irq,
  .event_in, .peer_send_event, .event_out, .sleeping, .sleep_deep, .wake
);

`default_nettype wire

// File: irq_ctrl_model.sv
// Interrupt controller model facing the sleep and wake controller.
// Assumes the bench holds raise for as long as the interrupt is pending.
`timescale 1ns/100ps
`default_nettype none

module irq_ctrl_model (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Requests from the bench
  input  wire logic                        raise,
  input  wire logic                        enab,
  input  wire logic [3:0]                  lag,
  input  wire logic                        priority_mask_bit,
  // Toward the controller
  output var  sleep_wake_pkg::irq_status_t irq
);
  logic [3:0] wait_q;
  logic       ripe;
  logic       ripe_q;

  // Pending only after lag cycles, so answers come promptly or slowly
  assign ripe = raise && (wait_q == lag);

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      wait_q <= 4'h0;
    else if (!raise)
      wait_q <= 4'h0;
    else if (!ripe)
      wait_q <= wait_q + 4'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ripe_q <= 1'b0;
    else
      ripe_q <= ripe;
  end

  // Disabled interrupts pend but never qualify; the mask blocks entry only
  assign irq.entry_ok       = ripe && enab && !priority_mask_bit;
  assign irq.above_priority = ripe && enab;
  assign irq.new_pending    = ripe && !ripe_q;
endmodule

`default_nettype wire

// File: test_core_sleep_wake_control.sv
// Self-checking bench for the sleep and wake controller.
// Assumes the checker is bound in and the wait-for-event path is built in.
`timescale 1ns/100ps
`default_nettype none

module test_core_sleep_wake_control;
  localparam logic [3:0] RQ_WINT = 4'h8;
  localparam logic [3:0] RQ_WEVT = 4'h4;
  localparam logic [3:0] RQ_SEND = 4'h2;
  localparam logic [3:0] RQ_RET  = 4'h1;
  localparam logic [1:0] OK      = sleep_wake_pkg::RESP_OKAY;

  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  logic [7:0]                  awaddr = 8'h00;
  logic [7:0]                  araddr = 8'h00;
  logic [31:0]                 wdata = 32'h0;
  logic                        awvalid = 1'b0;
  logic                        wvalid = 1'b0;
  logic                        bready = 1'b0;
  logic                        arvalid = 1'b0;
  logic                        rready = 1'b0;
  logic                        awready, wready, bvalid, arready, rvalid;
  logic [1:0]                  bresp, rresp;
  logic [31:0]                 rdata;
  sleep_wake_pkg::pipe_req_t   pipe_req = '0;
  sleep_wake_pkg::irq_status_t irq;
  logic                        mask = 1'b0;
  logic                        event_in = 1'b0;
  logic                        peer = 1'b0;
  logic                        raise = 1'b0;
  logic                        enab = 1'b1;
  logic [3:0]                  lag = 4'h0;
  logic                        cont, event_out, sleeping, sleep_deep, wake;
  logic [15:0]                 lfsr_q = 16'ha519;
  logic [33:0]                 exp_q[$];
  int                          err_total = 0;
  int                          check_count = 0;

  always #10 clk = ~clk;

  core_sleep_wake_control #(.ADDR_W(8), .WFE_ENABLE(1'b1)) DUT (
    .clk, .rst, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .pipe_req, .priority_mask_bit(mask), .wait_event_continue(cont), .irq,
    .event_in, .peer_send_event(peer), .event_out, .sleeping, .sleep_deep,
    .wake
  );

  irq_ctrl_model u_irq (
    .clk, .rst, .raise, .enab, .lag, .priority_mask_bit(mask), .irq
  );

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  task automatic check(input string what, input logic [33:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic hang();
    err_total++;
    end_of_test();
  endtask

  // Bus answers are compared against the oldest expectation
  always @(posedge clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      if (exp_q.size() == 0)
        hang();
      else if (rvalid && rready)
        check("read answer", {rresp, rdata}, exp_q.pop_front());
      else
        check("write answer", {bresp, 32'h0}, exp_q.pop_front());
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    int   n;
    logic aw_on;
    logic w_on;
    exp_q.push_back({e, 32'h0});
    aw_on = 1'b1;
    w_on  = 1'b1;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40 && (aw_on || w_on); n++) begin
      @(posedge clk);
      if (aw_on && awready) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 40 && !bvalid; n++)
      @(posedge clk);
    if (!bvalid)
      hang();
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready)
        break;
    end
    arvalid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rvalid)
        break;
    end
    if (n == 40)
      hang();
    rready <= 1'b0;
  endtask

  // One retiring instruction, held for a single clock edge
  task automatic pulse(input logic [3:0] r);
    @(posedge clk);
    pipe_req <= sleep_wake_pkg::pipe_req_t'(r);
    @(negedge clk);
    @(posedge clk);
    pipe_req <= '0;
    #1;
  endtask

  task automatic wait_wake();
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (wake)
        break;
    end
    if (n == 40)
      hang();
    check("sleeping at wake", {sleeping, sleep_deep}, 2'b00);
  endtask

  // Raise an interrupt after a random lag and wait for the wake
  task automatic irq_wake(input logic en);
    logic [15:0] r;
    r = rnd();
    @(posedge clk);
    lag   <= r[3:0];
    enab  <= en;
    raise <= 1'b1;
    wait_wake();
    @(posedge clk);
    raise <= 1'b0;
    mask  <= 1'b0;
    enab  <= 1'b1;
  endtask

  initial begin
    logic [15:0] r;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axi_rd(sleep_wake_pkg::CTRL_OFFSET, 34'h0);
    axi_rd(sleep_wake_pkg::STATUS_OFFSET, 34'h0);
    axi_rd(8'h0c, {sleep_wake_pkg::RESP_DECERR, 32'h0});
    axi_wr(8'h0c, 32'h0, sleep_wake_pkg::RESP_DECERR);
    pulse(RQ_WINT);
    check("plain sleep", {sleeping, sleep_deep}, 2'b10);
    irq_wake(1'b1);
    axi_wr(sleep_wake_pkg::CTRL_OFFSET, 32'h4, OK);
    axi_rd(sleep_wake_pkg::CTRL_OFFSET, 34'h4);
    pulse(RQ_WINT);
    check("deep sleep", {sleeping, sleep_deep}, 2'b11);
    @(posedge clk);
    mask <= 1'b1;
    irq_wake(1'b1);
    axi_wr(sleep_wake_pkg::CTRL_OFFSET, 32'h2, OK);
    pulse(RQ_RET);
    check("sleep after handler", {sleeping, sleep_deep}, 2'b10);
    irq_wake(1'b1);
    axi_wr(sleep_wake_pkg::CTRL_OFFSET, 32'h0, OK);
    pulse(RQ_RET);
    check("no sleep on return", sleeping, 1'b0);
    pulse(RQ_SEND);
    pulse(RQ_WEVT);
    check("run after send", sleeping, 1'b0);
    @(posedge clk);
    event_in <= 1'b1;
    @(posedge clk);
    event_in <= 1'b0;
    axi_rd(sleep_wake_pkg::STATUS_OFFSET, 34'h10);
    pulse(RQ_WEVT);
    check("run after event", sleeping, 1'b0);
    pulse(RQ_WEVT);
    check("event sleep", sleeping, 1'b1);
    r = rnd();
    repeat (r[2:0]) @(posedge clk);
    @(posedge clk);
    peer <= 1'b1;
    @(posedge clk);
    peer <= 1'b0;
    wait_wake();
    axi_wr(sleep_wake_pkg::CTRL_OFFSET, 32'h10, OK);
    pulse(RQ_WEVT);
    check("event sleep again", sleeping, 1'b1);
    irq_wake(1'b0);
    axi_rd(sleep_wake_pkg::ENTRY_COUNT_OFFSET, 34'h5);
    repeat (4) @(posedge clk);
    check("answers left", exp_q.size(), 34'h0);
    end_of_test();
  end
endmodule

`default_nettype wire
